// >>> verilog/gei_error_indicator.sv
`timescale 1ns/1ps
`default_nettype none
`include "gei_params.svh"
module gei_error_indicator #(
    parameter int unsigned MS_CYCLES = `GEI_MS_NS / `GEI_CLK_PERIOD_NS
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic heartbeat_error,
    input wire logic [5:0] dip_node_id,
    input wire logic [3:0] rotary_id_high,
    input wire logic [3:0] rotary_id_low,
    input wire logic serial_rs4xx_mode,
    input wire logic script_cmd_done,
    output logic state_led_red,
    output logic error_bit3_led,
    output logic error_bit2_led,
    output logic error_bit1_led,
    output logic error_bit0_led,
    output logic emcy_valid,
    input wire logic emcy_ready,
    output logic [15:0] emcy_code,
    output logic [15:0] emcy_detail,
    output logic [6:0] node_id,
    output logic [7:0] rotary_switch_value,
    output logic test_mode,
    output logic config_mode
);
    gei_pkg::gei_regs_s r;
    gei_pkg::gei_regs_s n;

    logic [31:0] wmerge;
    logic [31:0] rd_word;
    logic rd_hit;
    logic wr_hit;
    logic wr_now;
    logic raise_req;
    logic [3:0] raise_num;
    logic raise_prot;
    logic [15:0] raise_det;
    logic raise_ok;
    logic raise_serious;
    logic ms_tick;
    logic sec_tick;
    logic [8:0] half_ms;
    logic [7:0] rot_now;
    logic [31:0] wt_merge;
    logic hb_rise;
    logic showing;

    function automatic logic [31:0] gei_merge(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // handshake readies from state, all other outputs straight from registers
    assign s_axi_awready = clk_en & ~r.aw_have & ~r.bvalid;
    assign s_axi_wready = clk_en & ~r.w_have & ~r.bvalid;
    assign s_axi_arready = clk_en & ~r.rvalid;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rresp = r.rresp;
    assign s_axi_rdata = r.rdata;
    assign state_led_red = r.state_red;
    assign error_bit3_led = r.led[3];
    assign error_bit2_led = r.led[2];
    assign error_bit1_led = r.led[1];
    assign error_bit0_led = r.led[0];
    assign emcy_valid = r.emcy_valid;
    assign emcy_code = r.emcy_code;
    assign emcy_detail = r.emcy_detail;
    assign node_id = r.node_id;
    assign rotary_switch_value = r.rot_val;
    assign test_mode = r.test_mode;
    assign config_mode = r.config_mode;

    // read decode
    always_comb begin
        rd_hit = 1'h1;
        rd_word = 32'h0000_0000;
        case (s_axi_araddr)
            `GEI_OFF_CTRL: begin
                rd_word[`GEI_CTRL_EMCY_EN] = r.emcy_en;
                rd_word[`GEI_CTRL_LED_LO +: 4] = r.script_led;
            end
            `GEI_OFF_RAISE: begin
                rd_word = 32'h0000_0000;
            end
            `GEI_OFF_STATUS: begin
                rd_word[3:0] = r.err_num;
                rd_word[`GEI_ST_PROT] = r.err_prot;
                rd_word[`GEI_ST_SERIOUS] = (r.st == gei_pkg::GEI_SHOW_SERIOUS);
                rd_word[`GEI_ST_ACTIVE] = showing;
                rd_word[`GEI_ST_DET_LO +: 16] = r.err_detail;
            end
            `GEI_OFF_WARN_TIME: begin
                rd_word[15:0] = r.warn_time;
            end
            `GEI_OFF_NV_NODE: begin
                rd_word[6:0] = r.nv_node;
            end
            `GEI_OFF_ROTARY: begin
                rd_word[7:0] = r.rot_val;
                rd_word[`GEI_ROT_TEST] = r.test_mode;
                rd_word[`GEI_ROT_CONFIG] = r.config_mode;
                rd_word[`GEI_ROT_RSVD] = (r.rot_val == `GEI_ROT_CODE_RSVD);
                rd_word[`GEI_ROT_NODE_LO +: 7] = r.node_id;
            end
            default: begin
                rd_hit = 1'h0;
            end
        endcase
    end

    // write data merged with strobes
    always_comb begin
        wmerge = gei_merge(32'h0000_0000, r.w_data, r.w_strb);
        wt_merge = gei_merge({16'h0000, r.warn_time}, r.w_data, r.w_strb);
    end

    // write address check and error raise source
    always_comb begin
        wr_now = r.aw_have & r.w_have;
        case (r.aw_addr)
            `GEI_OFF_CTRL, `GEI_OFF_RAISE, `GEI_OFF_STATUS,
            `GEI_OFF_WARN_TIME, `GEI_OFF_NV_NODE, `GEI_OFF_ROTARY: begin
                wr_hit = 1'h1;
            end
            default: begin
                wr_hit = 1'h0;
            end
        endcase
        if (hb_rise) begin
            raise_req = 1'h1;
            raise_num = `GEI_HEARTBEAT_ERR;
            raise_prot = 1'h0;
            raise_det = 16'h0000;
            raise_ok = 1'h1;
        end else begin
            raise_req = wr_now & (r.aw_addr == `GEI_OFF_RAISE);
            raise_num = wmerge[3:0];
            raise_prot = wmerge[`GEI_RAISE_PROT];
            raise_det = wmerge[`GEI_RAISE_DET_LO +: 16];
            if (raise_prot) begin
                raise_ok = |(`GEI_PROT_VALID & (16'h0001 << raise_num));
            end else begin
                raise_ok = |(`GEI_SYS_VALID & (16'h0001 << raise_num));
            end
        end
        raise_serious = ~raise_prot & (raise_num <= `GEI_SERIOUS_MAX);
    end

    // timebase
    always_comb begin
        ms_tick = (r.cyc == 32'(MS_CYCLES - 1));
        sec_tick = ms_tick & (r.ms_in_sec == `GEI_MS_PER_S);
        half_ms = r.err_prot ? `GEI_PROT_HALF_MS : `GEI_SYS_HALF_MS;
        rot_now = r.rot_s2;
        hb_rise = r.hb_s2 & ~r.hb_prev;
        showing = (r.st != gei_pkg::GEI_IDLE);
    end

    always_comb begin
        // next state starts as a copy of the current one
        n = r;
        // input synchronisers
        n.rot_s1 = {rotary_id_high, rotary_id_low};
        n.rot_s2 = r.rot_s1;
        n.dip_s1 = dip_node_id;
        n.dip_s2 = r.dip_s1;
        n.hb_s1 = heartbeat_error;
        n.hb_s2 = r.hb_s1;
        n.hb_prev = r.hb_s2;
        n.rs_s1 = serial_rs4xx_mode;
        n.rs_s2 = r.rs_s1;

        // rotary sampling after synchronisers settle, then per script command
        if (r.boot != 2'h3) begin
            n.boot = r.boot + 2'h1;
        end
        if ((r.boot == 2'h2) | (script_cmd_done & (r.boot == 2'h3))) begin
            n.rot_val = rot_now;
        end
        n.test_mode = (r.rot_val == `GEI_ROT_CODE_TEST) & ~r.rs_s2;
        n.config_mode = (r.rot_val == `GEI_ROT_CODE_CONFIG) & ~r.rs_s2;

        // node id select
        if (r.dip_s2 == 6'h00) begin
            n.node_id = r.nv_node;
        end else begin
            n.node_id = {1'h0, r.dip_s2};
        end

        // timebase
        n.cyc = ms_tick ? 32'h0000_0000 : r.cyc + 32'h0000_0001;
        if (ms_tick) begin
            n.ms_in_sec = sec_tick ? 10'h000 : r.ms_in_sec + 10'h001;
            if (r.flash_ms == half_ms) begin
                n.flash_ms = 9'h000;
                n.flash_on = ~r.flash_on;
            end else begin
                n.flash_ms = r.flash_ms + 9'h001;
            end
        end

        // display state
        case (r.st)
            gei_pkg::GEI_IDLE: begin
                n.st = gei_pkg::GEI_IDLE;
            end
            gei_pkg::GEI_SHOW_WARN: begin
                if (sec_tick) begin
                    if (r.sec_left <= 16'h0001) begin
                        n.st = gei_pkg::GEI_IDLE;
                    end else begin
                        n.sec_left = r.sec_left - 16'h0001;
                    end
                end
            end
            gei_pkg::GEI_SHOW_SERIOUS: begin
                n.st = gei_pkg::GEI_SHOW_SERIOUS;
            end
            default: begin
                n.st = gei_pkg::GEI_IDLE;
            end
        endcase

        // emergency handshake
        if (r.emcy_valid & emcy_ready) begin
            n.emcy_valid = 1'h0;
        end

        // raise, a serious error is only displaced by another serious one
        if (raise_req & raise_ok &
            ((r.st != gei_pkg::GEI_SHOW_SERIOUS) | raise_serious)) begin
            n.err_num = raise_num;
            n.err_prot = raise_prot;
            n.err_detail = raise_det;
            n.st = raise_serious ? gei_pkg::GEI_SHOW_SERIOUS : gei_pkg::GEI_SHOW_WARN;
            n.sec_left = raise_prot ? r.warn_time : `GEI_WARN_SYS_S;
            // flash phase and second count restart with every accepted raise
            n.cyc = 32'h0000_0000;
            n.ms_in_sec = 10'h000;
            n.flash_ms = 9'h000;
            n.flash_on = 1'h1;
            if (r.emcy_en) begin
                n.emcy_valid = 1'h1;
                n.emcy_code = {`GEI_EMCY_CODE_HI, 4'h0, raise_num};
                n.emcy_detail = raise_det;
            end
        end

        // indicator outputs
        if (r.config_mode) begin
            n.state_red = 1'h0;
            n.led = r.script_led;
        end else if (showing) begin
            n.state_red = 1'h1;
            n.led = r.flash_on ? r.err_num : 4'h0;
        end else begin
            n.state_red = 1'h0;
            n.led = r.script_led;
        end

        // axi write channel
        if (s_axi_awvalid & s_axi_awready) begin
            n.aw_have = 1'h1;
            n.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid & s_axi_wready) begin
            n.w_have = 1'h1;
            n.w_data = s_axi_wdata;
            n.w_strb = s_axi_wstrb;
        end
        if (wr_now) begin
            n.aw_have = 1'h0;
            n.w_have = 1'h0;
            n.bvalid = 1'h1;
            n.bresp = wr_hit ? `GEI_RESP_OKAY : `GEI_RESP_SLVERR;
            if (r.aw_addr == `GEI_OFF_CTRL) begin
                if (r.w_strb[0]) begin
                    n.emcy_en = r.w_data[`GEI_CTRL_EMCY_EN];
                    n.script_led = r.w_data[`GEI_CTRL_LED_LO +: 4];
                end
            end
            if (r.aw_addr == `GEI_OFF_WARN_TIME) begin
                n.warn_time = wt_merge[15:0];
            end
            if ((r.aw_addr == `GEI_OFF_NV_NODE) & r.w_strb[0]) begin
                n.nv_node = r.w_data[6:0];
            end
        end
        if (r.bvalid & s_axi_bready) begin
            n.bvalid = 1'h0;
        end

        // axi read channel
        if (s_axi_arvalid & s_axi_arready) begin
            n.rvalid = 1'h1;
            n.rdata = rd_word;
            n.rresp = rd_hit ? `GEI_RESP_OKAY : `GEI_RESP_SLVERR;
        end
        if (r.rvalid & s_axi_rready) begin
            n.rvalid = 1'h0;
        end
    end

    // state register, frozen while clk_en is low
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            r <= '0;
            r.st <= gei_pkg::GEI_IDLE;
            r.emcy_en <= `GEI_EMCY_EN_RST;
            r.warn_time <= `GEI_WARN_TIME_RST;
            r.nv_node <= `GEI_NV_NODE_RST;
            r.node_id <= `GEI_NV_NODE_RST;
        end else if (clk_en) begin
            r <= n;
        end
    end
endmodule
`default_nettype wire

// >>> verilog/gei_params.svh
`ifndef GEI_PARAMS_SVH
`define GEI_PARAMS_SVH

// register byte offsets
`define GEI_OFF_CTRL 8'h00
`define GEI_OFF_RAISE 8'h04
`define GEI_OFF_STATUS 8'h08
`define GEI_OFF_WARN_TIME 8'h0c
`define GEI_OFF_NV_NODE 8'h10
`define GEI_OFF_ROTARY 8'h14

// field positions
`define GEI_CTRL_EMCY_EN 0
`define GEI_CTRL_LED_LO 4
`define GEI_RAISE_PROT 4
`define GEI_RAISE_DET_LO 16
`define GEI_ST_PROT 4
`define GEI_ST_SERIOUS 5
`define GEI_ST_ACTIVE 6
`define GEI_ST_DET_LO 16
`define GEI_ROT_TEST 8
`define GEI_ROT_CONFIG 9
`define GEI_ROT_RSVD 10
`define GEI_ROT_NODE_LO 16

// reset values
`define GEI_EMCY_EN_RST 1'h1
`define GEI_WARN_TIME_RST 16'h003c
`define GEI_NV_NODE_RST 7'h01

// error codes and classes
`define GEI_EMCY_CODE_HI 8'h61
`define GEI_SERIOUS_MAX 4'h5
`define GEI_HEARTBEAT_ERR 4'ha
`define GEI_SYS_VALID 16'h6fbe
`define GEI_PROT_VALID 16'hda28

// rotary switch codes
`define GEI_ROT_CODE_TEST 8'hee
`define GEI_ROT_CODE_CONFIG 8'hff
`define GEI_ROT_CODE_RSVD 8'hdd

// timing
`define GEI_CLK_PERIOD_NS 32'h0000_0005
`define GEI_MS_NS 32'h000f_4240
`define GEI_MS_PER_S 10'h3e7
`define GEI_WARN_SYS_S 16'h003c
`define GEI_SYS_HALF_MS 9'h0f9
`define GEI_PROT_HALF_MS 9'h1f3

// axi responses
`define GEI_RESP_OKAY 2'h0
`define GEI_RESP_SLVERR 2'h2

`endif

// >>> verilog/gei_pkg.sv
`default_nettype none
package gei_pkg;
    typedef enum logic [1:0] {
        GEI_IDLE = 2'b00,
        GEI_SHOW_WARN = 2'b01,
        GEI_SHOW_SERIOUS = 2'b10
    } gei_state_e;

    typedef struct packed {
        gei_state_e st;
        logic [3:0] err_num;
        logic err_prot;
        logic [15:0] err_detail;
        logic [15:0] sec_left;
        logic [9:0] ms_in_sec;
        logic [31:0] cyc;
        logic [8:0] flash_ms;
        logic flash_on;
        logic [3:0] led;
        logic state_red;
        logic emcy_valid;
        logic [15:0] emcy_code;
        logic [15:0] emcy_detail;
        logic emcy_en;
        logic [3:0] script_led;
        logic [15:0] warn_time;
        logic [6:0] nv_node;
        logic [6:0] node_id;
        logic [7:0] rot_s1;
        logic [7:0] rot_s2;
        logic [7:0] rot_val;
        logic [1:0] boot;
        logic test_mode;
        logic config_mode;
        logic [5:0] dip_s1;
        logic [5:0] dip_s2;
        logic hb_s1;
        logic hb_s2;
        logic hb_prev;
        logic rs_s1;
        logic rs_s2;
        logic aw_have;
        logic [7:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } gei_regs_s;
endpackage
`default_nettype wire

// >>> verification/gei_chk.sv
`timescale 1ns/1ps
`default_nettype none
module gei_chk (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic heartbeat_error,
    input wire logic [5:0] dip_node_id,
    input wire logic state_led_red,
    input wire logic emcy_valid,
    input wire logic emcy_ready,
    input wire logic [15:0] emcy_code,
    input wire logic [6:0] node_id,
    input wire logic [7:0] rotary_switch_value,
    input wire logic test_mode,
    input wire logic config_mode
);
    logic [3:0] up_r;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            up_r <= 4'h0;
        end else if (up_r != 4'hf) begin
            up_r <= up_r + 4'h1;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence s_take;
        emcy_valid && emcy_ready;
    endsequence
    sequence s_hb;
        $rose(heartbeat_error) && !state_led_red;
    endsequence
    sequence s_dip;
        (up_r == 4'hf && dip_node_id != 6'h00 && $stable(dip_node_id))[*6];
    endsequence
    AST_EMCY_HOLD: assert property (emcy_valid && !emcy_ready |=> emcy_valid)
        else $error("emergency dropped before taken");
    AST_EMCY_HI: assert property (emcy_valid |-> emcy_code[15:4] == 12'h610)
        else $error("emergency code high byte wrong");
    AST_EMCY_TAKE: assert property (s_take |=> !emcy_valid)
        else $error("emergency repeated after take");
    AST_HB: assert property (s_hb |-> ##[1:8] (emcy_valid && emcy_code == 16'h610a))
        else $error("heartbeat did not raise error ten");
    AST_NODE: assert property (s_dip |-> node_id == {1'h0, dip_node_id})
        else $error("node id does not follow dip");
    AST_ROT_TEST: assert property (test_mode |-> $past(rotary_switch_value) == 8'hee)
        else $error("test mode without ee");
    AST_ROT_CFG: assert property (config_mode |-> $past(rotary_switch_value) == 8'hff)
        else $error("config mode without ff");
    AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response repeated");
endmodule
bind gei_error_indicator gei_chk chk_u (.clock, .rst_b, .s_axi_bvalid, .s_axi_bready,
    .s_axi_rvalid, .s_axi_rready, .heartbeat_error, .dip_node_id, .state_led_red,
    .emcy_valid, .emcy_ready, .emcy_code, .node_id, .rotary_switch_value, .test_mode,
    .config_mode);
`default_nettype wire

// >>> verification/gei_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module gei_bus_model (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic slow,
    input wire logic emcy_valid,
    input wire logic [15:0] emcy_code,
    input wire logic [15:0] emcy_detail,
    output logic emcy_ready,
    output logic [15:0] last_code,
    output logic [15:0] last_detail,
    output int n_msg
);
    logic [1:0] wait_r;
    assign emcy_ready = !slow || wait_r == 2'h3;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wait_r <= 2'h0;
            last_code <= 16'h0000;
            last_detail <= 16'h0000;
            n_msg <= 0;
        end else if (emcy_valid && emcy_ready) begin
            wait_r <= 2'h0;
            last_code <= emcy_code;
            last_detail <= emcy_detail;
            n_msg <= n_msg + 1;
        end else if (emcy_valid) begin
            wait_r <= wait_r + 2'h1;
        end
    end
endmodule
`default_nettype wire

// >>> verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "gei_params.svh"
module tb;
    logic clock = 1'h0;
    logic rst_b = 1'h0;
    logic [7:0] awaddr = 8'h00;
    logic awvalid = 1'h0;
    logic [31:0] wdata = 32'h0000_0000;
    logic wvalid = 1'h0;
    logic bready = 1'h0;
    logic [7:0] araddr = 8'h00;
    logic arvalid = 1'h0;
    logic rready = 1'h0;
    logic hb = 1'h0;
    logic [5:0] dip = 6'h00;
    logic [3:0] rot_hi = 4'h0;
    logic [3:0] rot_lo = 4'h0;
    logic rs4xx = 1'h0;
    logic cmd_done = 1'h0;
    logic slow = 1'h0;
    wire logic awready, wready, bvalid, arready, rvalid, red, l3, l2, l1, l0, ev, er;
    wire logic tst, cfg;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [15:0] ec, ed, lc, ld;
    wire logic [6:0] node;
    wire logic [7:0] rot;
    wire logic [3:0] leds = {l3, l2, l1, l0};
    int n_msg;
    int mismatches = 0;
    int n_tests = 0;
    int cyc = 0;
    gei_error_indicator #(.MS_CYCLES(1)) dut_u (.clock, .rst_b, .clk_en(1'h1),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .heartbeat_error(hb), .dip_node_id(dip), .rotary_id_high(rot_hi),
        .rotary_id_low(rot_lo), .serial_rs4xx_mode(rs4xx), .script_cmd_done(cmd_done),
        .state_led_red(red), .error_bit3_led(l3), .error_bit2_led(l2), .error_bit1_led(l1),
        .error_bit0_led(l0), .emcy_valid(ev), .emcy_ready(er), .emcy_code(ec),
        .emcy_detail(ed), .node_id(node), .rotary_switch_value(rot), .test_mode(tst),
        .config_mode(cfg));
    gei_bus_model fb_u (.clock, .rst_b, .slow, .emcy_valid(ev), .emcy_code(ec),
        .emcy_detail(ed), .emcy_ready(er), .last_code(lc), .last_detail(ld), .n_msg);
    initial begin
        forever #2.5 clock = ~clock;
    end
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 90000) begin
            mismatches++;
            complete_run;
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge clock);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge clock);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'h0;
    endtask
    task automatic raise(input logic [4:0] pn, input logic [15:0] det);
        logic [1:0] r;
        wr(`GEI_OFF_RAISE, {det, 11'h000, pn}, r);
    endtask
    task automatic see_msg(input int n0, input logic [15:0] c);
        for (int i = 0; i < 30 && n_msg == n0; i++) @(posedge clock);
        chk("emcy count", n0 + 1, n_msg);
        chk("emcy code", c, lc);
    endtask
    task automatic t_reset;
        logic [31:0] d;
        logic [1:0] r;
        chk("node reset", 7'h01, node);
        chk("rotary reset", 8'h00, rot);
        rd(`GEI_OFF_CTRL, d, r);
        chk("ctrl reset", 32'h0000_0001, d);
        rd(`GEI_OFF_WARN_TIME, d, r);
        chk("warn reset", 32'h0000_003c, d);
        rd(8'h40, d, r);
        chk("unmapped resp", `GEI_RESP_SLVERR, r);
    endtask
    task automatic t_refuse;
        logic [4:0] bad [5] = '{5'h00, 5'h06, 5'h0c, 5'h0f, 5'h14};
        logic [1:0] r;
        int n0;
        wr(`GEI_OFF_CTRL, 32'h0000_0091, r);
        tick(4);
        chk("script leds", 4'h9, leds);
        foreach (bad[i]) begin
            n0 = n_msg;
            raise(bad[i], 16'h0000);
            tick(20);
            chk("bad code msg", n0, n_msg);
            chk("bad code red", 1'h0, red);
        end
    endtask
    task automatic t_node;
        logic [1:0] r;
        wr(`GEI_OFF_NV_NODE, 32'h0000_0064, r);
        chk("nv write resp", `GEI_RESP_OKAY, r);
        tick(8);
        chk("stored node", 7'h64, node);
        dip <= 6'h05;
        tick(10);
        chk("dip node", 7'h05, node);
        dip <= 6'h00;
    endtask
    task automatic rot_case(input logic [3:0] h, input logic [3:0] l, input logic rs,
        input logic t, input logic c);
        logic [31:0] d;
        logic [1:0] r;
        rot_hi <= h;
        rot_lo <= l;
        rs4xx <= rs;
        tick(6);
        cmd_done <= 1'h1;
        @(posedge clock);
        cmd_done <= 1'h0;
        tick(6);
        chk("rotary value", {h, l}, rot);
        chk("test mode", t, tst);
        chk("config mode", c, cfg);
        rd(`GEI_OFF_ROTARY, d, r);
        chk("reserved flag", {h, l} == 8'hdd, d[10]);
        if (c) chk("config leds", 5'h09, {red, leds});
    endtask
    task automatic t_heartbeat;
        int n0;
        n0 = n_msg;
        hb <= 1'h1;
        tick(3);
        hb <= 1'h0;
        see_msg(n0, 16'h610a);
        tick(120);
        chk("hb on", 5'h1a, {red, leds});
        tick(250);
        chk("hb off", 5'h10, {red, leds});
        tick(58600);
        chk("warn held", 1'h1, red);
        tick(2000);
        chk("warn cleared", 5'h09, {red, leds});
    endtask
    task automatic t_protocol;
        logic [1:0] r;
        int n0;
        wr(`GEI_OFF_WARN_TIME, 32'h0000_0001, r);
        n0 = n_msg;
        raise(5'h1b, 16'h0000);
        see_msg(n0, 16'h610b);
        tick(250);
        chk("prot on", 5'h1b, {red, leds});
        tick(500);
        chk("prot off", 5'h10, {red, leds});
        raise(5'h1e, 16'h0000);
        see_msg(n0 + 1, 16'h610e);
        tick(5);
        chk("newest shown", 5'h1e, {red, leds});
        tick(900);
        chk("timer restart", 1'h1, red);
        tick(200);
        chk("prot cleared", 1'h0, red);
    endtask
    task automatic t_serious;
        logic [31:0] d;
        logic [1:0] r;
        int n0;
        slow <= 1'h1;
        n0 = n_msg;
        raise(5'h03, 16'h1234);
        see_msg(n0, 16'h6103);
        chk("detail", 16'h1234, ld);
        raise(5'h09, 16'h0000);
        tick(20);
        chk("warn ignored", n0 + 1, n_msg);
        tick(3000);
        chk("serious held", 1'h1, red);
        rd(`GEI_OFF_STATUS, d, r);
        chk("status", 32'h1234_0063, d);
    endtask
    initial begin
        repeat (2) @(posedge clock);
        rst_b <= 1'h1;
        tick(6);
        t_reset;
        t_refuse;
        t_node;
        rot_case(4'he, 4'he, 1'h0, 1'h1, 1'h0);
        rot_case(4'he, 4'he, 1'h1, 1'h0, 1'h0);
        rot_case(4'hf, 4'hf, 1'h0, 1'h0, 1'h1);
        rot_case(4'hd, 4'hd, 1'h0, 1'h0, 1'h0);
        rot_case(4'h0, 4'h0, 1'h0, 1'h0, 1'h0);
        t_heartbeat;
        t_protocol;
        t_serious;
        complete_run;
    end
endmodule
`default_nettype wire
